/* include/pmi_pkg.sv */
package pmi_pkg;

	// ----------------------------------------------------------------
	// Port modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PMI_MII_PHY,
		PMI_MII_MAC,
		PMI_RMII
	} pmi_mode_e;

	// ----------------------------------------------------------------
	// Timing and reset values
	// ----------------------------------------------------------------
	localparam real PMI_MCLK_MHZ = 250.0;
	localparam real PMI_REF_MHZ = 50.0;
	localparam real PMI_MII100_MHZ = 25.0;
	localparam real PMI_MII10_MHZ = 2.5;
	// Half period of a generated MII clock, in link-clock (50 MHz) cycles.
	localparam int PMI_HALF100 = int'(PMI_REF_MHZ / PMI_MII100_MHZ / 2.0);
	localparam int PMI_HALF10 = int'(PMI_REF_MHZ / PMI_MII10_MHZ / 2.0);
	localparam logic [4:0] PMI_DIV_RST = 5'h00;
	localparam logic PMI_STRAP_RST = 1'b0;
	localparam logic [1:0] PMI_BUS_RST = 2'h0;

endpackage : pmi_pkg

/* rtl/pmi_port.sv */
`timescale 1ns/1ps
// Function
// - MII transmit nibble follows transmit clock.
// - RMII transmit bits follow 50 MHz reference.
// - Transmit bit 3 strap enables reference output.
// - Strap high drives reference on receive bit 3.
// - Transmit clock driven as PHY, input as MAC.
// - MAC mode: transmit error pin is error.
// - PHY mode: transmit error high selects bypass.
// - Receive valid only with valid receive lanes.
// - Receive valid strap picks PHY or MAC.
// - MII receive nibble launched on the generated clock, driven out as receive clock only as PHY.
// - RMII receive bits on reference; bit 2 unused.
// - Receive bit 2 strap picks SPI speed.
// - Receive bits 1:0 straps pick management mode.
// - Carrier sense output as PHY, input as MAC.
// - RMII carrier pin becomes general-purpose line.
// - RMII ignores transmit data bit 2.
// - Receive clock driven as PHY, input as MAC.
// - Collision output as PHY, input as MAC.
module pmi_port (
	// System clock and reset
	input wire logic i_mclk,
	input wire logic i_reset,
	// Link clock: 50 MHz reference (RMII) or MII clock source
	input wire logic i_link_clk,
	// Configuration: RMII variant select, speed
	input wire logic i_rmii_sel,
	input wire logic i_speed_100,
	// Pin: transmit side from partner
	input wire logic i_tx_en,
	input wire logic [3:0] i_txd,
	input wire logic i_tx_er,
	// Pin: transmit clock (three signals)
	input wire logic i_tx_clk,
	output logic o_tx_clk,
	output logic o_tx_clk_oe,
	// Pin: receive clock
	input wire logic i_rx_clk,
	output logic o_rx_clk,
	output logic o_rx_clk_oe,
	// Pin: receive valid and data (straps read as inputs)
	input wire logic i_rx_dv,
	input wire logic [3:0] i_rxd,
	output logic o_rx_dv,
	output logic o_rx_dv_oe,
	output logic [3:0] o_rxd,
	output logic [3:0] o_rxd_oe,
	// Pin: carrier sense and collision
	input wire logic i_crs,
	output logic o_crs,
	output logic o_crs_oe,
	input wire logic i_col,
	output logic o_col,
	output logic o_col_oe,
	// Switch side: receive stream toward partner (link domain)
	input wire logic i_sw_rx_valid,
	input wire logic [3:0] i_sw_rx_data,
	input wire logic i_sw_crs,
	input wire logic i_sw_col,
	// Switch side: transmit stream from partner (transmit-clock domain in MII, link domain in RMII)
	output logic o_sw_tx_valid,
	output logic [3:0] o_sw_tx_data,
	output logic o_sw_tx_err,
	// Carrier pin as general-purpose line in RMII
	input wire logic i_gpio_out,
	input wire logic i_gpio_oe,
	output logic o_carrier_pin_gpio,
	// Status (system domain)
	output pmi_pkg::pmi_mode_e o_mode,
	output logic o_bypass_select,
	output logic o_ref_out_enable_strap,
	output logic o_spi_high_speed,
	output logic [1:0] o_mgmt_bus_mode,
	output logic o_far_crs,
	output logic o_far_col
);
	import pmi_pkg::*;

	// ----------------------------------------------------------------
	// Strap capture, system domain
	// ----------------------------------------------------------------
	// Straps are sampled in the first cycle after reset release, after a
	// two-stage synchroniser, then frozen until the next reset.
	logic [7:0] pin_s1_r, pin_s2_r;
	logic cap_done_r, cap_done_nxt;
	pmi_mode_e mode_r, mode_nxt;
	logic refen_r, refen_nxt, spi_r, spi_nxt;
	logic [1:0] bus_r, bus_nxt;
	logic [7:0] pin_raw;

	assign pin_raw = {i_rmii_sel, i_txd[3], i_rx_dv, i_rxd[2:0], i_tx_er, i_crs};

	always_comb begin
		cap_done_nxt = 1'b1;
		mode_nxt = mode_r;
		refen_nxt = refen_r;
		spi_nxt = spi_r;
		bus_nxt = bus_r;
		if (!cap_done_r) begin
			if (pin_s2_r[7])
				mode_nxt = PMI_RMII;
			else if (pin_s2_r[5])
				mode_nxt = PMI_MII_PHY;
			else
				mode_nxt = PMI_MII_MAC;
			refen_nxt = pin_s2_r[7] & pin_s2_r[6];
			spi_nxt = pin_s2_r[4];
			bus_nxt = pin_s2_r[3:2];
		end
	end

	always_ff @(posedge i_mclk) begin
		pin_s1_r <= pin_raw;
		pin_s2_r <= pin_s1_r;
		if (i_reset) begin
			cap_done_r <= 1'b0;
			mode_r <= PMI_MII_MAC;
			refen_r <= PMI_STRAP_RST;
			spi_r <= PMI_STRAP_RST;
			bus_r <= PMI_BUS_RST;
		end else begin
			cap_done_r <= cap_done_nxt;
			mode_r <= mode_nxt;
			refen_r <= refen_nxt;
			spi_r <= spi_nxt;
			bus_r <= bus_nxt;
		end
	end

	// ----------------------------------------------------------------
	// System-domain status
	// ----------------------------------------------------------------
	// Far-end pin levels come from the synchroniser's second stage only.
	logic bypass_r, bypass_nxt, fcrs_r, fcrs_nxt, fcol_r, fcol_nxt;
	logic col_s1_r, col_s2_r;

	always_comb begin
		bypass_nxt = (mode_r == PMI_MII_PHY) && cap_done_r && pin_s2_r[1];
		fcrs_nxt = (mode_r == PMI_MII_MAC) && pin_s2_r[0];
		fcol_nxt = (mode_r == PMI_MII_MAC) && col_s2_r;
	end

	always_ff @(posedge i_mclk) begin
		col_s1_r <= i_col;
		col_s2_r <= col_s1_r;
		if (i_reset) begin
			bypass_r <= 1'b0;
			fcrs_r <= 1'b0;
			fcol_r <= 1'b0;
		end else begin
			bypass_r <= bypass_nxt;
			fcrs_r <= fcrs_nxt;
			fcol_r <= fcol_nxt;
		end
	end

	assign o_mode = mode_r;
	assign o_bypass_select = bypass_r;
	assign o_ref_out_enable_strap = refen_r;
	assign o_spi_high_speed = spi_r;
	assign o_mgmt_bus_mode = bus_r;
	assign o_far_crs = fcrs_r;
	assign o_far_col = fcol_r;

	// ----------------------------------------------------------------
	// Configuration crossing into the link domain
	// ----------------------------------------------------------------
	// Straps are static after capture, so a two-flop level crossing of
	// each bit is safe; a glitch can occur in the capture cycle or when bypass_r or i_speed_100 changes.
	logic [5:0] cfg_s1_r, cfg_s2_r, cfg_src;
	logic lk_rst_s1_r, lk_rst_s2_r;
	logic lk_phy, lk_rmii, lk_refen, lk_bypass, lk_fast;

	assign cfg_src = {mode_r == PMI_MII_PHY, mode_r == PMI_RMII, refen_r, bypass_r, i_speed_100, cap_done_r};

	always_ff @(posedge i_link_clk) begin
		cfg_s1_r <= cfg_src;
		cfg_s2_r <= cfg_s1_r;
		lk_rst_s1_r <= i_reset;
		lk_rst_s2_r <= lk_rst_s1_r;
	end

	assign lk_phy = cfg_s2_r[5] & cfg_s2_r[0];
	assign lk_rmii = cfg_s2_r[4] & cfg_s2_r[0];
	assign lk_refen = cfg_s2_r[3];
	assign lk_bypass = cfg_s2_r[2];
	assign lk_fast = cfg_s2_r[1];

	// ----------------------------------------------------------------
	// Link domain: MII clock generation and pin data paths
	// ----------------------------------------------------------------
	// In PHY-side MII the device makes the transmit and receive clocks by
	// dividing the 50 MHz link clock; data changes on the falling edge
	// of the generated clock so the partner samples it on the rising edge.
	logic [4:0] div_r, div_nxt;
	logic mclk_r, mclk_nxt, launch;
	logic rxdv_r, rxdv_nxt, crs_r, crs_nxt, col_r, col_nxt;
	logic [3:0] rxd_r, rxd_nxt;
	logic txv_r, txv_nxt, txe_r, txe_nxt;
	logic [3:0] txd_r, txd_nxt;
	logic [4:0] half;
	logic gpo_r, gpe_r;

	assign half = lk_fast ? 5'(PMI_HALF100) : 5'(PMI_HALF10);

	always_comb begin
		div_nxt = div_r + 5'h01;
		mclk_nxt = mclk_r;
		if (div_r >= half - 5'h01) begin
			div_nxt = PMI_DIV_RST;
			mclk_nxt = ~mclk_r;
		end
		// In RMII every rising link edge launches; in MII only the fall of the clock.
		launch = lk_rmii || (mclk_r && div_r >= half - 5'h01);
		rxdv_nxt = rxdv_r;
		rxd_nxt = rxd_r;
		crs_nxt = crs_r;
		col_nxt = col_r;
		if (launch) begin
			rxdv_nxt = i_sw_rx_valid && !lk_bypass;
			rxd_nxt = rxdv_nxt ? i_sw_rx_data : 4'h0;
			if (lk_rmii)
				rxd_nxt[3:2] = 2'h0;
			crs_nxt = i_sw_crs && !lk_bypass;
			col_nxt = i_sw_col && !lk_bypass;
		end
		txv_nxt = i_tx_en && !lk_bypass;
		txd_nxt = i_txd;
		if (lk_rmii)
			txd_nxt[3:2] = 2'h0;
		// error pin as error in MAC mode
		txe_nxt = i_tx_er && !lk_phy && !lk_rmii;
	end

	// MII transmit sampled on its own clock
	// These flops run in every mode; in RMII the output mux simply ignores them.
	always_ff @(posedge i_tx_clk) begin
		txv_r <= txv_nxt;
		txd_r <= txd_nxt;
		txe_r <= txe_nxt;
	end

	always_ff @(posedge i_link_clk) begin
		gpo_r <= i_gpio_out;
		gpe_r <= i_gpio_oe;
		if (lk_rst_s2_r) begin
			div_r <= PMI_DIV_RST;
			mclk_r <= 1'b0;
			rxdv_r <= 1'b0;
			rxd_r <= 4'h0;
			crs_r <= 1'b0;
			col_r <= 1'b0;
		end else begin
			div_r <= div_nxt;
			mclk_r <= mclk_nxt;
			rxdv_r <= rxdv_nxt;
			rxd_r <= rxd_nxt;
			crs_r <= crs_nxt;
			col_r <= col_nxt;
		end
	end

	// RMII transmit capture on the reference clock.
	logic rtxv_r, rtxe_r;
	logic [3:0] rtxd_r;
	always_ff @(posedge i_link_clk) begin
		rtxv_r <= txv_nxt;
		rtxd_r <= txd_nxt;
		rtxe_r <= 1'b0;
	end

	assign o_sw_tx_valid = lk_rmii ? rtxv_r : txv_r;
	assign o_sw_tx_data = lk_rmii ? rtxd_r : txd_r;
	assign o_sw_tx_err = lk_rmii ? rtxe_r : txe_r;

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	// transmit clock out as PHY
	assign o_tx_clk = mclk_r;
	assign o_tx_clk_oe = lk_phy;
	assign o_rx_clk = mclk_r;
	assign o_rx_clk_oe = lk_phy;
	assign o_rx_dv = rxdv_r;
	assign o_rx_dv_oe = cfg_s2_r[0];
	// reference clock on receive bit 3 (forwarded link clock)
	assign o_rxd = {lk_rmii ? (lk_refen & i_link_clk) : rxd_r[3], rxd_r[2:0]};
	assign o_rxd_oe = {cfg_s2_r[0] & (!lk_rmii | lk_refen), cfg_s2_r[0] & !lk_rmii, {2{cfg_s2_r[0]}}};
	assign o_crs = lk_rmii ? gpo_r : crs_r;
	assign o_crs_oe = lk_rmii ? gpe_r : lk_phy;
	assign o_carrier_pin_gpio = pin_s2_r[0];
	assign o_col = col_r;
	assign o_col_oe = lk_phy;

endmodule : pmi_port

/* tb/pmi_partner.sv */
`timescale 1ns/1ps
module pmi_partner (
	// Transmit clock and run control
	input wire logic i_clk,
	input wire logic i_run,
	// Transmit pins toward the port
	output logic o_tx_en,
	output logic [3:0] o_txd
);
	integer seed = 97553;
	// Idle nibbles are random too, so a port that ignores the enable shows it.
	// launch after edge
	always @(posedge i_clk) begin
		#1;
		if (i_run) begin
			o_tx_en = $random(seed);
			o_txd = $random(seed);
		end
	end
endmodule : pmi_partner

/* tb/pmi_port_properties.sv */
`timescale 1ns/1ps
module pmi_port_chk import pmi_pkg::*; (
	// Clock, reset and watched ports
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_rmii_sel,
	input wire logic i_tx_er,
	input wire logic i_rx_dv,
	input wire logic [3:0] i_rxd,
	input wire logic [3:0] i_txd,
	input wire logic o_tx_clk_oe,
	input wire logic o_rx_clk_oe,
	input wire logic o_col_oe,
	input wire logic o_crs_oe,
	input wire pmi_pkg::pmi_mode_e o_mode,
	input wire logic o_bypass_select,
	input wire logic o_ref_out_enable_strap,
	input wire logic o_spi_high_speed,
	input wire logic [1:0] o_mgmt_bus_mode
);
	// ------------------------------------------------
	// Helper state
	// ------------------------------------------------
	logic [4:0] cnt_r, cnt_nxt;
	logic [5:0] pin_r, pin_nxt;
	logic ok;
	pmi_mode_e m_exp;
	// Pins are remembered while reset holds, so a late capture is caught too.
	always_comb begin
		cnt_nxt = i_reset ? 5'h0 : cnt_r + 5'(cnt_r != 5'h1f);
		pin_nxt = i_reset ? {i_rmii_sel, i_rx_dv, i_txd[3], i_rxd[2:0]} : pin_r;
	end
	// Registers only.
	always_ff @(posedge i_mclk) begin
		cnt_r <= cnt_nxt;
		pin_r <= pin_nxt;
	end
	// Settled well past the crossing into the link domain.
	assign ok = cnt_r == 5'h1f;
	assign m_exp = pin_r[5] ? PMI_RMII : (pin_r[4] ? PMI_MII_PHY : PMI_MII_MAC);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	// ------------------------------------------------
	// Properties
	// ------------------------------------------------
	property p_mode; ok |-> o_mode == m_exp; endproperty
	a_mode: assert property (p_mode) else $error("mode strap wrong");
	property p_mgmt; ok |-> o_spi_high_speed == pin_r[2] && o_mgmt_bus_mode == pin_r[1:0]; endproperty
	a_mgmt: assert property (p_mgmt) else $error("bus straps wrong");
	property p_ref; ok && pin_r[5] |-> o_ref_out_enable_strap == pin_r[3]; endproperty
	a_ref: assert property (p_ref) else $error("ref strap wrong");
	property p_hold; ok |-> $stable(o_mode) && $stable(o_mgmt_bus_mode); endproperty
	a_hold: assert property (p_hold) else $error("straps moved");
	property p_txc; ok |-> o_tx_clk_oe == (o_mode == PMI_MII_PHY); endproperty
	a_txc: assert property (p_txc) else $error("tx clock direction");
	property p_rxc; ok |-> o_rx_clk_oe == (o_mode == PMI_MII_PHY); endproperty
	a_rxc: assert property (p_rxc) else $error("rx clock direction");
	property p_col; ok |-> o_col_oe == (o_mode == PMI_MII_PHY); endproperty
	a_col: assert property (p_col) else $error("collision direction");
	property p_crs; ok && o_mode != PMI_RMII |-> o_crs_oe == (o_mode == PMI_MII_PHY); endproperty
	a_crs: assert property (p_crs) else $error("carrier direction");
	property p_byp; (ok && o_mode == PMI_MII_PHY && i_tx_er) [*3] |=> o_bypass_select; endproperty
	a_byp: assert property (p_byp) else $error("bypass missing");
	property p_mac; ok && o_mode != PMI_MII_PHY |-> !o_bypass_select; endproperty
	a_mac: assert property (p_mac) else $error("bypass outside phy");
endmodule : pmi_port_chk

bind pmi_port pmi_port_chk u_chk (
	.i_mclk(i_mclk), .i_reset(i_reset), .i_rmii_sel(i_rmii_sel), .i_tx_er(i_tx_er),
	.i_rx_dv(i_rx_dv), .i_rxd(i_rxd), .i_txd(i_txd), .o_tx_clk_oe(o_tx_clk_oe),
	.o_rx_clk_oe(o_rx_clk_oe), .o_col_oe(o_col_oe), .o_crs_oe(o_crs_oe), .o_mode(o_mode),
	.o_bypass_select(o_bypass_select), .o_ref_out_enable_strap(o_ref_out_enable_strap),
	.o_spi_high_speed(o_spi_high_speed), .o_mgmt_bus_mode(o_mgmt_bus_mode)
);

/* tb/pmi_port_tb_top.sv */
`timescale 1ns/1ps
module pmi_port_tb_top;
	import pmi_pkg::*;
	logic i_mclk = 0, i_reset = 1, i_link_clk = 0, i_rmii_sel = 0, run = 0, i_tx_er = 0, i_speed_100 = 1;
	logic i_gpio_out = 0, i_gpio_oe = 0, i_sw_rx_valid = 0, i_sw_crs = 0, i_sw_col = 0, strap_dv = 0, p_en;
	logic far_sig = 0;
	logic [3:0] i_sw_rx_data = 0, strap_txd = 0, strap_rxd = 0, p_txd;
	logic [4:0] cap, s0;
	logic [6:0] s1;
	logic o_tx_clk, o_tx_clk_oe, o_rx_clk, o_rx_clk_oe, o_rx_dv, o_rx_dv_oe, o_crs, o_crs_oe;
	logic o_col, o_col_oe, o_sw_tx_valid, o_sw_tx_err, o_carrier_pin_gpio, o_bypass_select;
	logic o_ref_out_enable_strap, o_spi_high_speed, o_far_crs, o_far_col;
	logic [3:0] o_rxd, o_rxd_oe, o_sw_tx_data;
	logic [1:0] o_mgmt_bus_mode;
	pmi_mode_e o_mode;
	integer seed = 97553, n_mismatch = 0, checks_done = 0, cyc = 0;
	// Pin levels: the port's drive wins, else pull-downs or strap resistors.
	// A MAC-mode port takes its transmit clock, carrier and collision from the far PHY.
	wire logic i_tx_clk = o_tx_clk_oe === 1'b1 ? o_tx_clk : i_link_clk;
	wire logic i_rx_clk = o_rx_clk_oe === 1'b1 ? o_rx_clk : 1'b0;
	wire logic i_crs = o_crs_oe === 1'b1 ? o_crs : far_sig;
	wire logic i_col = o_col_oe === 1'b1 ? o_col : far_sig;
	wire logic i_rx_dv = o_rx_dv_oe === 1'b1 ? o_rx_dv : strap_dv;
	wire logic [3:0] i_rxd = (o_rxd & o_rxd_oe) | (strap_rxd & ~o_rxd_oe);
	wire logic i_tx_en = run ? p_en : 1'b0;
	wire logic [3:0] i_txd = run ? p_txd : strap_txd;
	wire logic txc = i_rmii_sel ? i_link_clk : i_tx_clk;
	pmi_port dut (
		.i_mclk(i_mclk), .i_reset(i_reset), .i_link_clk(i_link_clk), .i_rmii_sel(i_rmii_sel),
		.i_speed_100(i_speed_100), .i_tx_en(i_tx_en), .i_txd(i_txd), .i_tx_er(i_tx_er),
		.i_tx_clk(i_tx_clk), .o_tx_clk(o_tx_clk), .o_tx_clk_oe(o_tx_clk_oe),
		.i_rx_clk(i_rx_clk), .o_rx_clk(o_rx_clk), .o_rx_clk_oe(o_rx_clk_oe),
		.i_rx_dv(i_rx_dv), .i_rxd(i_rxd), .o_rx_dv(o_rx_dv), .o_rx_dv_oe(o_rx_dv_oe),
		.o_rxd(o_rxd), .o_rxd_oe(o_rxd_oe), .i_crs(i_crs), .o_crs(o_crs), .o_crs_oe(o_crs_oe),
		.i_col(i_col), .o_col(o_col), .o_col_oe(o_col_oe),
		.i_sw_rx_valid(i_sw_rx_valid), .i_sw_rx_data(i_sw_rx_data), .i_sw_crs(i_sw_crs), .i_sw_col(i_sw_col),
		.o_sw_tx_valid(o_sw_tx_valid), .o_sw_tx_data(o_sw_tx_data), .o_sw_tx_err(o_sw_tx_err),
		.i_gpio_out(i_gpio_out), .i_gpio_oe(i_gpio_oe), .o_carrier_pin_gpio(o_carrier_pin_gpio),
		.o_mode(o_mode), .o_bypass_select(o_bypass_select), .o_ref_out_enable_strap(o_ref_out_enable_strap),
		.o_spi_high_speed(o_spi_high_speed), .o_mgmt_bus_mode(o_mgmt_bus_mode),
		.o_far_crs(o_far_crs), .o_far_col(o_far_col)
	);
	pmi_partner u_far (.i_clk(txc), .i_run(run), .o_tx_en(p_en), .o_txd(p_txd));
	// ------------------------------------------------
	// Clocks, checks and closing
	// ------------------------------------------------
	initial forever #2 i_mclk = ~i_mclk;
	initial begin
		#1.3;
		forever #6 i_link_clk = ~i_link_clk;
	end
	task chk(input logic [3:0] seen, input logic [3:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_sim
	// A hung run counts as a failure.
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			end_sim;
		end
	end
	// Taken at the rising edge, looked at half a period later.
	always @(posedge txc) cap = {i_tx_en, i_txd};
	always @(negedge txc) begin
		#1;
		if (run && !i_tx_er) begin
			chk(o_sw_tx_valid, cap[4]);
			if (cap[4]) chk(o_sw_tx_data, i_rmii_sel ? cap[3:0] & 4'h3 : cap[3:0]);
		end
	end
	// Switch-side receive stream; the edge that samples a word also puts it on the pins.
	always @(posedge i_link_clk) begin
		#1;
		if (run && i_rmii_sel) begin
			chk(o_rx_dv, s0[4]);
			if (s0[4]) chk(o_rxd[2:0], {1'b0, s0[1:0]});
			if (strap_txd[3]) chk(o_rxd[3], 1);
		end
		{i_sw_rx_valid, i_sw_rx_data, i_sw_crs, i_sw_col} = run ? $random(seed) : 0;
		s0 = {i_sw_rx_valid, i_sw_rx_data};
	end
	always @(negedge i_link_clk) begin
		#1;
		if (run && i_rmii_sel && strap_txd[3]) chk(o_rxd[3], 0);
	end
	// MII receive: the word is taken at the receive clock's fall and must stand at its rise.
	always @(negedge i_rx_clk) s1 = {i_sw_rx_valid, i_sw_rx_data, i_sw_crs, i_sw_col};
	always @(posedge i_rx_clk) begin
		#1;
		if (run && !i_tx_er) begin
			chk(o_rx_dv, s1[6]);
			if (s1[6]) chk(o_rxd, s1[5:2]);
			chk({o_crs, o_col}, s1[1:0]);
		end
	end
	// Reset with random straps, then let traffic run.
	task boot(input logic rm, input logic dv, input logic sp);
		@(posedge i_mclk);
		#1;
		{run, i_reset, i_tx_er, i_rmii_sel, strap_dv} = {3'h2, rm, dv};
		i_speed_100 = sp;
		{strap_rxd, strap_txd, i_gpio_out, i_gpio_oe} = $random(seed);
		repeat (10) @(posedge i_mclk);
		#1 i_reset = 0;
		repeat (40) @(posedge i_mclk);
		#1 run = 1;
		repeat (300) @(posedge i_mclk);
	endtask : boot
	initial begin
		boot(0, 1, 1);
		// The slow clock needs a full period before bypass shows on both paths.
		boot(0, 1, 0);
		#1 i_tx_er = 1;
		repeat (100) @(posedge i_mclk);
		#1;
		chk({o_bypass_select, o_sw_tx_valid, o_rx_dv}, 4'h4);
		boot(1, 0, 1);
		chk({o_crs_oe, o_crs & i_gpio_oe, o_carrier_pin_gpio}, {i_gpio_oe, {2{i_gpio_out & i_gpio_oe}}});
		boot(0, 0, 1);
		chk(o_mode, PMI_MII_MAC);
		#1 {i_tx_er, far_sig} = 2'h3;
		repeat (20) @(posedge i_mclk);
		#1;
		chk({o_sw_tx_err, o_bypass_select, o_far_crs, o_far_col}, 4'hB);
		end_sim;
	end
endmodule : pmi_port_tb_top
